// >>> hdl/tsr_pkg.sv
// Constants and types for the transmitter shutdown and recovery block
package tsr_pkg;
    // Clock and slow tick
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int CNT_W = 14;
    // Times in seconds, then in ticks
    localparam int unsigned DELAY_S = 25;
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned HOUR_S = 3600;
    localparam logic [CNT_W-1:0] DELAY_TICKS = CNT_W'(DELAY_S * 1000 / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] MINUTE_TICKS = CNT_W'(MINUTE_S * 1000 / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] HOUR_TICKS = CNT_W'(HOUR_S * 1000 / TICK_PERIOD_MS);
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    // Interrupt bit positions
    localparam int IRQ_W = 4;
    localparam int IRQ_SHUTDOWN = 0;
    localparam int IRQ_PULSE = 1;
    localparam int IRQ_RECOVERED = 2;
    localparam int IRQ_PERMANENT = 3;
    // Values after reset
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [1:0] ATTEMPT_RST = 2'h0;
    // Read view of block state
    typedef struct packed {
        logic [24:0] zero;
        logic [1:0] attempt;
        logic activity;
        logic permanent;
        logic detect;
        logic pulse;
        logic latch;
    } tsr_state_t;
endpackage

// >>> hdl/tsr_top.sv
// Shutdown monitor and recovery sequencer with an APB register file
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Reset pulses at 1 minute, 1, 2 and 3 hours after shutdown.
// - Transmitter running a minute after a pulse returns sequencer to idle.
// - Shutdown within a minute of a pulse waits for next slot.
// - Still down a minute after fourth pulse latches permanent shutdown.
// - Detect flop cleared when idle holds counter at zero.
// - Latch turning on sets detect flop; counter counts ticks from zero.
// - First pulse decoded at one-minute count, higher points excluded.
// - Reset pulse forces latch off while timing continues.
// - Manual button returns sequencer and latch to initial state.
// - RF current below reference removes activity.
// - Each activity transition restarts the shutdown delay.
// - No activity transitions for 25 seconds sets the latch.
// - Steady tone without transitions also leads to shutdown.
// - Latch set turns preamp relay off until latch is reset.
module tsr_top #(
    parameter int unsigned TICK_CYCLES = tsr_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Detector and panel inputs
    input wire logic rf_current_ok,
    input wire logic tone_present,
    input wire logic manual_reset_button,
    // Transmitter controls
    output logic preamp_supply_relay,
    output logic latch_sense_line,
    output logic reset_pulse,
    output logic permanent_shutdown,
    output logic irq,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import tsr_pkg::*;

    // Every interval counts whole slow ticks, so each decode point carries
    // up to one tick of phase against the event that started it. The tick
    // period is the only scaling knob: decode points stay in seconds and
    // follow whatever rate the prescaler gives.

    // Schedule decode: pulse points and the checks one minute after them
    function automatic logic is_pulse_pt(input logic [CNT_W-1:0] c);
        return (c == MINUTE_TICKS) || (c == HOUR_TICKS)
            || (c == CNT_W'(2 * HOUR_TICKS)) || (c == CNT_W'(3 * HOUR_TICKS));
    endfunction

    // Check points sit one minute after each pulse point, never on a pulse tick
    function automatic logic is_check_pt(input logic [CNT_W-1:0] c);
        return is_pulse_pt(CNT_W'(c - MINUTE_TICKS)) && (c > MINUTE_TICKS);
    endfunction

    // Synchronisers and edge history
    logic [1:0] rf_sync_reg, tone_sync_reg, btn_sync_reg;
    logic act_prev_reg;
    // Prescaler
    logic [31:0] pre_reg;
    logic tick;
    // Monitor and sequencer state
    logic [CNT_W-1:0] delay_reg, elapsed_time_counter;
    logic shutdown_latch, latch_prev_reg, shutdown_detect_flop;
    logic pulse_reg, perm_reg;
    logic [1:0] attempt_reg;
    // Registers
    logic soft_clr_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
    logic [31:0] prdata_reg;

    // Only the second stage is read, so a first stage caught mid-change
    // never reaches the monitor or the sequencer.
    // two-flop synchronisers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rf_sync_reg <= 2'h0;
            tone_sync_reg <= 2'h0;
            btn_sync_reg <= 2'h0;
        end else begin
            rf_sync_reg <= {rf_sync_reg[0], rf_current_ok};
            tone_sync_reg <= {tone_sync_reg[0], tone_present};
            btn_sync_reg <= {btn_sync_reg[0], manual_reset_button};
        end
    end

    // Either detector low holds the node low; a healthy transmitter keys
    // the tone, so the node follows the code elements.
    // low RF removes the activity indication
    wire activity_node = rf_sync_reg[1] & tone_sync_reg[1];
    // any transition of the activity node
    wire act_edge = activity_node ^ act_prev_reg;
    // button or software clear restores initial state
    wire clear_all = btn_sync_reg[1] | soft_clr_reg;

    // Free-running prescaler: ticks keep their phase across shutdowns,
    // which is the source of the one-tick spread on every interval.
    // Held at 32 bits so the one-second default period fits.
    // prescaler gives one tick enable per slow period
    assign tick = (pre_reg == TICK_CYCLES - 1);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_reg <= 32'h0;
        end else if (tick) begin
            pre_reg <= 32'h0;
        end else begin
            pre_reg <= pre_reg + 32'h1;
        end
    end

    // Delay expiry; only a transition, pulse, latch or clear restarts it, so a steady tone expires
    // nominal 25 s without transitions
    wire delay_done = tick && (delay_reg == DELAY_TICKS - CNT_W'(1));
    // No new shutdown while latched or while a pulse is restarting the set
    wire delay_trigger = delay_done && !shutdown_latch && !pulse_reg;

    // Count held at zero while latched or pulsing, so a restarted
    // transmitter always gets a full delay before it can be shut again.
    // Shutdown monitor timer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            act_prev_reg <= 1'b0;
            delay_reg <= '0;
        end else begin
            act_prev_reg <= activity_node;
            // restart on transition, on pulse and while latched
            if (act_edge || pulse_reg || shutdown_latch || clear_all) begin
                delay_reg <= '0;
            end else if (tick) begin
                delay_reg <= delay_reg + CNT_W'(1);
            end
        end
    end

    // Priority is clear, then pulse, then monitor: a pulse meeting a fresh
    // expiry in one cycle wins, so the restart is never swallowed.
    // Shutdown latch; a reset pulse overrides, then it may set again
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shutdown_latch <= 1'b0;
            latch_prev_reg <= 1'b0;
        end else begin
            latch_prev_reg <= shutdown_latch;
            if (clear_all || pulse_reg) begin
                shutdown_latch <= 1'b0;
            end else if (delay_trigger) begin
                shutdown_latch <= 1'b1;
            end
        end
    end

    // The latch edge, not its level, starts a run; a held latch starts one only
    // rising edge of the latch is the shutdown event
    wire latch_rise = shutdown_latch & ~latch_prev_reg;
    // first point decoded as exactly one minute
    wire first_pulse_decoder = (elapsed_time_counter == MINUTE_TICKS);
    // Pulse and check decodes share the tick strobe and the detect flop,
    // so nothing in the schedule fires while the sequencer is idle.
    wire pulse_due = tick && shutdown_detect_flop && !perm_reg
        && (first_pulse_decoder || is_pulse_pt(elapsed_time_counter));
    wire check_due = tick && shutdown_detect_flop && !perm_reg
        && is_check_pt(elapsed_time_counter);
    // Only the final check can end in permanent shutdown
    wire last_check = elapsed_time_counter == CNT_W'(3 * HOUR_TICKS + MINUTE_TICKS);
    wire recovered = check_due && !shutdown_latch;
    wire give_up = check_due && shutdown_latch && last_check;

    // While permanent, a later latch rise is ignored; only the button, a
    // software clear or a power-up leaves that state.
    // Recovery sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shutdown_detect_flop <= 1'b0;
            elapsed_time_counter <= '0;
            pulse_reg <= 1'b0;
            perm_reg <= 1'b0;
            attempt_reg <= ATTEMPT_RST;
        end else if (clear_all) begin
            shutdown_detect_flop <= 1'b0;
            elapsed_time_counter <= '0;
            pulse_reg <= 1'b0;
            perm_reg <= 1'b0;
            attempt_reg <= ATTEMPT_RST;
        end else begin
            // Pulse register only moves on a tick, so its width is one period
            // pulse lasts one tick
            if (tick) begin
                pulse_reg <= pulse_due;
            end
            // schedule counts from the original shutdown
            if (pulse_due) begin
                attempt_reg <= attempt_reg + 2'h1;
            end
            // Idle: wait for the latch edge; counting: advance once per tick
            if (!shutdown_detect_flop) begin
                // counter held at zero while idle
                elapsed_time_counter <= '0;
                shutdown_detect_flop <= latch_rise && !perm_reg;
            end else if (recovered || give_up) begin
                // running a minute after a pulse, back to idle
                shutdown_detect_flop <= 1'b0;
                elapsed_time_counter <= '0;
                attempt_reg <= ATTEMPT_RST;
                perm_reg <= give_up;
            end else if (tick) begin
                // re-shutdown just keeps counting to next slot
                elapsed_time_counter <= elapsed_time_counter + CNT_W'(1);
            end
        end
    end

    // Relay drive is a gate of two flops, with no decode that could glitch
    // latch or permanent state drops the preamp relay
    assign preamp_supply_relay = ~shutdown_latch & ~perm_reg;
    assign latch_sense_line = shutdown_latch;
    assign reset_pulse = pulse_reg;
    assign permanent_shutdown = perm_reg;

    // Interrupt events
    // Each event is a one-cycle strobe; the status bits hold it until
    // software writes a one back.
    assign irq_ev[IRQ_SHUTDOWN] = latch_rise;
    assign irq_ev[IRQ_PULSE] = pulse_due;
    assign irq_ev[IRQ_RECOVERED] = recovered;
    assign irq_ev[IRQ_PERMANENT] = give_up;
    // Level output: high while any unmasked status bit stands
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // APB decode; zero wait states, data captured in the setup cycle
    // A status read may lag the live state by one clock, since data is
    // captured in the setup cycle; writes land at the access edge.
    // Unmapped offsets answer with an error and leave every register alone.
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_state = paddr == OFS_STATE;
    wire hit_count = paddr == OFS_COUNT;
    wire hit_stat = paddr == OFS_IRQ_STAT;
    wire hit_mask = paddr == OFS_IRQ_MASK;
    wire mapped = hit_ctrl | hit_state | hit_count | hit_stat | hit_mask;
    // No wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_reg;

    // Status view in the bit order of the read map; upper bits read zero
    tsr_state_t state_view;
    assign state_view = '{zero: '0, attempt: attempt_reg, activity: activity_node,
        permanent: perm_reg, detect: shutdown_detect_flop, pulse: pulse_reg,
        latch: shutdown_latch};

    wire [31:0] rd_mux = hit_state ? 32'(state_view)
        : hit_count ? 32'(elapsed_time_counter)
        : hit_stat ? 32'(irq_stat_reg)
        : hit_mask ? 32'(irq_mask_reg)
        : 32'h0;

    // Read data register
    // Writes load zero, so a stale read value never stands after a write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= 32'h0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // Control, mask and sticky status; a new event beats a write-one clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            soft_clr_reg <= 1'b0;
            irq_mask_reg <= IRQ_MASK_RST;
            irq_stat_reg <= '0;
        end else begin
            // One-clock strobe; it joins the button on the clear path
            soft_clr_reg <= wr_en && hit_ctrl && pwdata[0];
            if (wr_en && hit_mask) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
            if (wr_en && hit_stat) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
        end
    end

endmodule // tsr_top

`default_nettype wire

// >>> verif/tsr_properties.sv
// Port checker for the shutdown and recovery block
`timescale 1ns/1ps
`default_nettype none
module tsr_properties #(
    parameter int unsigned TICK_CYCLES = tsr_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Inputs
    input wire logic rf_current_ok,
    input wire logic tone_present,
    input wire logic manual_reset_button,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    // Outputs
    input wire logic preamp_supply_relay,
    input wire logic latch_sense_line,
    input wire logic reset_pulse,
    input wire logic permanent_shutdown,
    input wire logic pready,
    input wire logic pslverr
);
    int unsigned pw_cnt, gap, quiet;
    logic act_q, pul_q, seen;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Pulse width, pulse spacing and input quiet time, in clocks
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            {pw_cnt, gap, quiet, act_q, pul_q, seen} <= '0;
        end else begin
            pw_cnt <= reset_pulse ? pw_cnt + 1 : 0;
            pul_q <= reset_pulse;
            gap <= (reset_pulse && !pul_q) ? 0 : gap + 1;
            seen <= seen | (reset_pulse && !pul_q);
            act_q <= rf_current_ok & tone_present;
            quiet <= (act_q != (rf_current_ok & tone_present)) ? 0 : quiet + 1;
        end
    end
    relay_gate_a: assert property (preamp_supply_relay == (!latch_sense_line && !permanent_shutdown))
        else $error("relay disagrees with latch state");
    pulse_width_a: assert property ($fell(reset_pulse) |-> pw_cnt == TICK_CYCLES)
        else $error("reset pulse not one tick wide");
    pulse_clear_a: assert property ($rose(reset_pulse) |-> ##[0:1] !latch_sense_line)
        else $error("pulse did not clear latch");
    pulse_prio_a: assert property ($rose(latch_sense_line) |-> !reset_pulse)
        else $error("latch set during pulse");
    quiet_delay_a: assert property ($rose(latch_sense_line) |-> quiet >= 24 * TICK_CYCLES)
        else $error("latch set before shutdown delay");
    pulse_gap_a: assert property ($rose(reset_pulse) && seen |-> gap >= 59 * TICK_CYCLES)
        else $error("reset pulses too close");
    perm_cause_a: assert property ($rose(permanent_shutdown) |-> $past(latch_sense_line))
        else $error("permanent without shutdown");
    button_clear_a: assert property (manual_reset_button [*4] |->
        !latch_sense_line && !permanent_shutdown && !reset_pulse)
        else $error("button did not clear state");
    apb_refuse_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr && pready)
        else $error("unmapped access not refused");
    cover property ($rose(reset_pulse));
    cover property ($rose(permanent_shutdown));
    cover property (pslverr);
endmodule // tsr_properties
bind tsr_top tsr_properties #(.TICK_CYCLES(TICK_CYCLES)) u_tsr_properties (.clk_sys(clk_sys),
    .nrst(nrst), .rf_current_ok(rf_current_ok), .tone_present(tone_present),
    .manual_reset_button(manual_reset_button), .psel(psel), .penable(penable), .paddr(paddr),
    .preamp_supply_relay(preamp_supply_relay), .latch_sense_line(latch_sense_line),
    .reset_pulse(reset_pulse), .permanent_shutdown(permanent_shutdown), .pready(pready),
    .pslverr(pslverr));
`default_nettype wire

// >>> verif/tsr_xmtr_model.sv
// Behavioural transmitter detectors seen by the block
`timescale 1ns/1ps
`default_nettype none
module tsr_xmtr_model (
    // Clock
    input wire logic clk_sys,
    // Fault mode: 0 healthy, 1 dead carrier, 2 steady tone
    input wire logic [1:0] mode,
    // Preamp drive from the block
    input wire logic preamp_supply_relay,
    // Detector outputs
    output logic rf_current_ok,
    output logic tone_present
);
    logic [3:0] key_cnt = 4'h0;
    logic key = 1'b0;
    // Code keying, well inside the shutdown delay
    always_ff @(posedge clk_sys) begin
        key_cnt <= key_cnt + 4'h1;
        if (key_cnt == 4'hf) key <= ~key;
    end
    // No carrier and no tone without preamp drive
    assign rf_current_ok = preamp_supply_relay && mode != 2'h1;
    assign tone_present = rf_current_ok && (mode == 2'h2 || key);
endmodule // tsr_xmtr_model
`default_nettype wire

// >>> verif/transmitter_shutdown_recovery_tb_top.sv
// Self-checking bench for the shutdown and recovery block
`timescale 1ns/1ps
`default_nettype none
module transmitter_shutdown_recovery_tb_top;
    import tsr_pkg::*;
    localparam int T = 4;
    logic clk_sys = 0, nrst = 0, btn = 0, psel = 0, penable = 0, pwrite = 0, pq = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, m;
    logic [1:0] mode = 0;
    logic rf, tone, relay, latch, pulse, perm, irq, pready, pslverr;
    int n_mismatch = 0, compares = 0, dt;
    time t_sd, t_act;
    logic act_q = 0;
    logic [31:0] rdq[$];
    int pexp[$];
    tsr_top #(.TICK_CYCLES(T)) u_tsr_top (.clk_sys(clk_sys), .nrst(nrst), .rf_current_ok(rf),
        .tone_present(tone), .manual_reset_button(btn), .preamp_supply_relay(relay),
        .latch_sense_line(latch), .reset_pulse(pulse), .permanent_shutdown(perm), .irq(irq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    tsr_xmtr_model u_tsr_xmtr_model (.clk_sys(clk_sys), .mode(mode),
        .preamp_supply_relay(relay), .rf_current_ok(rf), .tone_present(tone));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {psel, penable} <= 2'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_latch;
        for (int n = 0; n < 200 * T && latch !== 1'b1; n++) @(negedge clk_sys);
        t_sd = $time;
        chk("latch", 1, latch);
    endtask
    task give_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Read data taken at the access edge, against the oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready) chk("prdata", rdq.pop_front(), prdata);
    end
    // Edge at which the last change of the detector pair is seen
    always @(posedge clk_sys) begin
        act_q <= rf & tone;
        if ((rf & tone) !== act_q) t_act = $time;
    end
    // Pulse time since shutdown, one tick of phase allowed
    always @(posedge clk_sys) begin
        pq <= pulse;
        if (pulse === 1'b1 && pq === 1'b0) begin
            dt = (pexp.size() == 0) ? 99999 : int'(($time - t_sd) / 50) - pexp.pop_front() * T;
            chk("pulse time", 1, dt >= -T - 2 && dt <= T + 2);
        end
    end
    initial begin
        #3000000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        void'($urandom(39));
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(OFS_COUNT, 0);
        rd(OFS_IRQ_MASK, {28'h0, IRQ_MASK_RST});
        rd(8'h20, 0);
        m = $urandom;
        apb(1'b1, OFS_IRQ_MASK, m);
        rd(OFS_IRQ_MASK, {28'h0, m[3:0]});
        apb(1'b1, OFS_IRQ_MASK, 32'hf);
        repeat (40 * T + $urandom_range(40)) @(posedge clk_sys);
        chk("latch", 0, latch);
        // Dead carrier, then healthy again once the pulse lets it run
        mode <= 2'h1;
        wait_latch();
        chk("delay", 1, (t_sd - t_act) / 50 inside {[24 * T : 26 * T + 4]});
        chk("relay", 0, relay);
        // Status bit lands one clock after the latch edge
        @(negedge clk_sys);
        chk("irq", 1, irq);
        apb(1'b1, OFS_IRQ_STAT, 32'hf);
        mode <= 2'h0;
        pexp.push_back(60);
        repeat (124 * T) @(negedge clk_sys);
        chk("pulses", 0, pexp.size());
        chk("relay", 1, relay);
        rd(OFS_COUNT, 0);
        rd(OFS_IRQ_STAT, 32'h6);
        // Steady tone: all four pulses fail, then permanent shutdown
        mode <= 2'h2;
        wait_latch();
        chk("delay", 1, (t_sd - t_act) / 50 inside {[24 * T : 26 * T + 4]});
        pexp.push_back(60);
        pexp.push_back(3600);
        pexp.push_back(7200);
        pexp.push_back(10800);
        repeat (10864 * T) @(negedge clk_sys);
        chk("pulses", 0, pexp.size());
        chk("permanent", 1, perm);
        chk("relay", 0, relay);
        rd(OFS_STATE, 32'h9);
        // Software clear out of permanent shutdown, then a fresh shutdown
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (2) @(negedge clk_sys);
        chk("soft clear", 3'b001, {perm, latch, relay});
        @(posedge clk_sys);
        mode <= 2'h1;
        wait_latch();
        // Button in mid-sequence clears latch and sequencer
        @(posedge clk_sys);
        mode <= 2'h0;
        btn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        btn <= 1'b0;
        @(negedge clk_sys);
        chk("cleared", 3'b001, {perm, latch, relay});
        rd(OFS_COUNT, 0);
        @(negedge clk_sys);
        give_verdict;
    end
endmodule // transmitter_shutdown_recovery_tb_top
`default_nettype wire
